/* logic/cft_pkg.sv */
// Shared constants for the CAN transceiver supervisory block.
// Assumes a 40 MHz pclk and an APB master with 32-bit data.
package cft_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 25;     // pclk period
	localparam int FILTER_TIME_NS  = 3200;   // Bus phase filter time
	localparam int WAKE_TIME_NS    = 1000000; // Wake pattern timeout
	localparam int CLAMP_TIME_NS   = 1600;   // Clamp detect time
	localparam int DOM_HOLD_NS     = 1000000; // Dominant hold timeout
	// Least times and the dominant hold timeout round up, the wake timeout rounds down
	localparam int FILTER_CYC = (FILTER_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WAKE_CYC   = WAKE_TIME_NS / CLK_PERIOD_NS;
	localparam int CLAMP_CYC  = (CLAMP_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DOM_HOLD_CYC = (DOM_HOLD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_OFS  = 8'h00; // Read-only state
	localparam logic [7:0] CONTROL_OFS = 8'h04; // Control bits

	// Status fields
	localparam int ST_MODE_LSB  = 0; // Two bits of mode
	localparam int ST_WAKE_BIT  = 2; // Wake request pending
	localparam int ST_OT_BIT    = 3; // Overtemperature lock
	localparam int ST_TO_BIT    = 4; // Dominant hold timeout lock
	localparam int ST_UV_BIT    = 5; // Supply undervoltage
	localparam int ST_WSTG_LSB  = 6; // Two bits of pattern stage

	// Control fields
	localparam int CT_CLAMP_EN_BIT = 0; // Clamp detection enable
	localparam logic CT_CLAMP_EN_RST = 1'b1;

	// ----------------------------------------------------------------
	// Pin synchroniser slots and their reset levels
	// ----------------------------------------------------------------
	localparam int PIN_TXD = 0; // Transmit data from controller
	localparam int PIN_LPS = 1; // Low power select
	localparam int PIN_CMP = 2; // Bus comparator, 1 = dominant
	localparam int PIN_RXS = 3; // Receive pin sensed level
	localparam int PIN_N   = 4;
	localparam logic [3:0] PIN_RST = 4'hb; // Pulled-up pins read high

	// ----------------------------------------------------------------
	// Mode and wake stage encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		M_UNPOWERED,
		M_STANDBY,
		M_NORMAL,
		M_SILENT
	} cft_mode_t;

	typedef enum logic [1:0] {
		W_IDLE,
		W_DOM1,
		W_REC,
		W_DOM2
	} cft_wstage_t;
endpackage : cft_pkg

/* logic/cft_transceiver.sv */
// Supervisory logic of one CAN transceiver channel: mode control,
// wake pattern filter, undervoltage and overtemperature handling,
// dominant hold timeout and receive clamp detection, with APB status.
// Assumes analog monitors give undervoltage and overtemperature as
// flags already synchronous to pclk; pins arrive asynchronously.
`timescale 1ns/1ps
module cft_transceiver #(
	parameter int FILT_CYC  = cft_pkg::FILTER_CYC,
	parameter int WAKE_CYC  = cft_pkg::WAKE_CYC,
	parameter int CLAMP_CYC = cft_pkg::CLAMP_CYC,
	parameter int DOM_CYC   = cft_pkg::DOM_HOLD_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        txd_pin,
	input  wire logic        low_power_select,
	input  wire logic        bus_level_comparator,
	input  wire logic        rxd_sense,
	input  wire logic        undervoltage,
	input  wire logic        overtemperature,
	output logic             rxd_out,
	output logic             drive_dominant,
	output logic             bias_enable
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int FW = $clog2(FILT_CYC + 1);
	localparam int WW = $clog2(WAKE_CYC + 1);
	localparam int CW = $clog2(CLAMP_CYC + 1);
	localparam int DW = $clog2(DOM_CYC + 1);

	logic [cft_pkg::PIN_N-1:0] raw;     // Pins as they arrive
	logic [cft_pkg::PIN_N-1:0] pin_lvl; // Settled pin levels

	assign raw = {rxd_sense, bus_level_comparator, low_power_select,
		txd_pin};

	// Three stages; a level is taken only when stages two and three
	// agree, so a single metastable sample never reaches the logic.
	// Pulled-up pins reset high so a floating pin reads high.
	genvar gi;
	generate
		for (gi = 0; gi < cft_pkg::PIN_N; gi++) begin : g_sync
			logic s1_r;
			logic s2_r;
			logic s3_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_r <= cft_pkg::PIN_RST[gi];
					s2_r <= cft_pkg::PIN_RST[gi];
					s3_r <= cft_pkg::PIN_RST[gi];
					pin_lvl[gi] <= cft_pkg::PIN_RST[gi];
				end else begin
					s1_r <= raw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						pin_lvl[gi] <= s3_r;
					end
				end
			end
		end
	endgenerate

	wire logic txd_hi  = pin_lvl[cft_pkg::PIN_TXD]; // Recessive request
	wire logic lps_hi  = pin_lvl[cft_pkg::PIN_LPS]; // Standby request
	wire logic cmp_dom = pin_lvl[cft_pkg::PIN_CMP]; // Bus dominant
	wire logic rxs_hi  = pin_lvl[cft_pkg::PIN_RXS]; // Receive pin high

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	cft_pkg::cft_mode_t   mode_r;    // Operating mode
	cft_pkg::cft_wstage_t wstage_r;  // Wake pattern progress
	logic          clamp_en_r;       // Clamp detection enabled
	logic          wake_r;           // Wake request pending
	logic          ot_lock_r;        // Drivers held off by heat
	logic          to_lock_r;        // Drivers held off by timeout
	logic          flt_lvl_r;        // Filtered bus level, 1 = dominant
	logic [FW-1:0] flt_cnt_r;        // Filter persistence count
	logic [WW-1:0] wake_cnt_r;       // Time since first dominant
	logic [CW-1:0] clamp_cnt_r;      // Unseen dominant duration
	logic [DW-1:0] dom_cnt_r;        // Transmit low duration
	logic          clamp_hit;        // Clamp detected this cycle
	logic          wake_hit;         // Pattern completed this cycle

	// ----------------------------------------------------------------
	// Mode control
	// ----------------------------------------------------------------
	// Undervoltage acts as a synchronous reset of the mode; the select
	// pin is not looked at until the supply is back.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= cft_pkg::M_UNPOWERED;
		end else if (undervoltage) begin
			mode_r <= cft_pkg::M_UNPOWERED;
		end else begin
			case (mode_r)
				// Recovery always lands in standby first
				cft_pkg::M_UNPOWERED: mode_r <= cft_pkg::M_STANDBY;
				// Only the host leaves standby; a wake does not.
				cft_pkg::M_STANDBY: begin
					if (!lps_hi && txd_hi) begin
						mode_r <= cft_pkg::M_NORMAL;
					end
				end
				cft_pkg::M_NORMAL: begin
					if (lps_hi) begin
						mode_r <= cft_pkg::M_STANDBY;
					end else if (clamp_hit) begin
						mode_r <= cft_pkg::M_SILENT;
					end
				end
				cft_pkg::M_SILENT: begin
					if (lps_hi) begin
						mode_r <= cft_pkg::M_STANDBY;
					end else if (!rxs_hi) begin
						mode_r <= cft_pkg::M_NORMAL;
					end
				end
				default: mode_r <= cft_pkg::M_UNPOWERED;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Wake filter: bus phases must persist before they count
	// ----------------------------------------------------------------
	// The filtered level flips only after FILT_CYC samples that differ;
	// shorter glitches restart the count and are lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_lvl_r <= 1'b0;
			flt_cnt_r <= '0;
		end else if (undervoltage) begin
			flt_lvl_r <= 1'b0;
			flt_cnt_r <= '0;
		end else if (cmp_dom == flt_lvl_r) begin
			flt_cnt_r <= '0;
		end else if (flt_cnt_r >= FW'(FILT_CYC - 1)) begin
			flt_lvl_r <= cmp_dom;
			flt_cnt_r <= '0;
		end else begin
			flt_cnt_r <= flt_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Wake pattern sequencer
	// ----------------------------------------------------------------
	// Stages advance on filtered edges only, so a bus stuck dominant
	// stays in the first stage and times out.
	assign wake_hit = (wstage_r == cft_pkg::W_REC) && flt_lvl_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wstage_r   <= cft_pkg::W_IDLE;
			wake_cnt_r <= '0;
		end else if (undervoltage) begin
			wstage_r   <= cft_pkg::W_IDLE;
			wake_cnt_r <= '0;
		end else begin
			case (wstage_r)
				cft_pkg::W_IDLE: begin
					wake_cnt_r <= '0;
					if (flt_lvl_r) begin
						wstage_r <= cft_pkg::W_DOM1;
					end
				end
				cft_pkg::W_DOM1, cft_pkg::W_REC: begin
					wake_cnt_r <= wake_cnt_r + 1'b1;
					if (wake_cnt_r >= WW'(WAKE_CYC - 1)) begin
						wstage_r <= cft_pkg::W_IDLE;
					end else if (wake_hit) begin
						wstage_r <= cft_pkg::W_DOM2;
					end else if (!flt_lvl_r) begin
						wstage_r <= cft_pkg::W_REC;
					end
				end
				// Rearm once the bus has gone recessive again
				cft_pkg::W_DOM2: begin
					wake_cnt_r <= '0;
					if (!flt_lvl_r) begin
						wstage_r <= cft_pkg::W_IDLE;
					end
				end
				default: wstage_r <= cft_pkg::W_IDLE;
			endcase
		end
	end

	// Wake request latches in standby; leaving standby clears it, and
	// the clear wins over a pattern seen in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_r <= 1'b0;
		end else if (mode_r == cft_pkg::M_STANDBY && wake_hit &&
			wake_cnt_r < WW'(WAKE_CYC - 1) && !undervoltage) begin
			wake_r <= 1'b1;
		end else if (mode_r != cft_pkg::M_STANDBY || undervoltage) begin
			wake_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Overtemperature lock
	// ----------------------------------------------------------------
	// Release needs the heat gone and transmit data high, which stops
	// the drivers oscillating around the trip point.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_lock_r <= 1'b0;
		end else if (undervoltage) begin
			ot_lock_r <= 1'b0;
		end else if (overtemperature) begin
			ot_lock_r <= 1'b1;
		end else if (txd_hi) begin
			ot_lock_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Dominant hold timeout
	// ----------------------------------------------------------------
	// A stuck-low transmit input cannot block the bus forever; any high
	// phase restarts the timer and lifts the lock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dom_cnt_r <= '0;
			to_lock_r <= 1'b0;
		end else if (undervoltage || txd_hi) begin
			dom_cnt_r <= '0;
			to_lock_r <= 1'b0;
		end else if (dom_cnt_r >= DW'(DOM_CYC - 1)) begin
			to_lock_r <= 1'b1;
		end else begin
			dom_cnt_r <= dom_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Receive clamp detection
	// ----------------------------------------------------------------
	// Counts while the bus is dominant but the receive pin stays high;
	// only in normal mode, so silent mode exit is not re-triggered.
	assign clamp_hit = clamp_en_r && cmp_dom && rxs_hi &&
		(clamp_cnt_r >= CW'(CLAMP_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_cnt_r <= '0;
		end else if (undervoltage || mode_r != cft_pkg::M_NORMAL ||
			!cmp_dom || !rxs_hi) begin
			clamp_cnt_r <= '0;
		end else if (!clamp_hit) begin
			clamp_cnt_r <= clamp_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	// All outputs are registered; they lag the settled inputs by one
	// cycle. Silent and locked states keep the driver recessive.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_dominant <= 1'b0;
			rxd_out        <= 1'b1;
			bias_enable    <= 1'b0;
		end else if (undervoltage) begin
			drive_dominant <= 1'b0;
			rxd_out        <= 1'b1;
			bias_enable    <= 1'b0;
		end else begin
			drive_dominant <= (mode_r == cft_pkg::M_NORMAL) && !txd_hi &&
				!ot_lock_r && !overtemperature && !to_lock_r;
			bias_enable <= (mode_r == cft_pkg::M_NORMAL) ||
				(mode_r == cft_pkg::M_SILENT);
			case (mode_r)
				cft_pkg::M_STANDBY: rxd_out <= !wake_r;
				cft_pkg::M_NORMAL:  rxd_out <= !cmp_dom;
				cft_pkg::M_SILENT:  rxd_out <= !cmp_dom;
				default:            rxd_out <= 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	wire logic setup_ph  = psel && !penable;          // Setup cycle
	wire logic access_ok = psel && penable && pready; // Completing access
	wire logic mapped    = (paddr == cft_pkg::STATUS_OFS) || // Register hit
		(paddr == cft_pkg::CONTROL_OFS);

	// No wait states: ready and data are loaded at the setup edge and
	// stand for the single access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !mapped;
			prdata  <= 32'h0000_0000;
			if (setup_ph && !pwrite) begin
				case (paddr)
					cft_pkg::STATUS_OFS: begin
						prdata[cft_pkg::ST_MODE_LSB +: 2] <= mode_r;
						prdata[cft_pkg::ST_WAKE_BIT] <= wake_r;
						prdata[cft_pkg::ST_OT_BIT]   <= ot_lock_r;
						prdata[cft_pkg::ST_TO_BIT]   <= to_lock_r;
						prdata[cft_pkg::ST_UV_BIT]   <= undervoltage;
						prdata[cft_pkg::ST_WSTG_LSB +: 2] <= wstage_r;
					end
					cft_pkg::CONTROL_OFS: begin
						prdata[cft_pkg::CT_CLAMP_EN_BIT] <= clamp_en_r;
					end
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register write takes effect at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_en_r <= cft_pkg::CT_CLAMP_EN_RST;
		end else if (access_ok && pwrite &&
			paddr == cft_pkg::CONTROL_OFS) begin
			clamp_en_r <= pwdata[cft_pkg::CT_CLAMP_EN_BIT];
		end
	end
endmodule : cft_transceiver

/* testbench/cft_checker.sv */
// Assertion checker for the transceiver supervisory block.
// Assumes it is bound onto cft_transceiver and sees its ports only.
`timescale 1ns/1ps
module cft_checker #(
	parameter int FILT_CYC  = 8,
	parameter int WAKE_CYC  = 200,
	parameter int CLAMP_CYC = 6,
	parameter int DOM_CYC   = 50
) (
	input logic       pclk,
	input logic       presetn,
	input logic [7:0] paddr,
	input logic       psel,
	input logic       penable,
	input logic       pready,
	input logic       pslverr,
	input logic       txd_pin,
	input logic       low_power_select,
	input logic       bus_level_comparator,
	input logic       rxd_sense,
	input logic       undervoltage,
	input logic       overtemperature,
	input logic       rxd_out,
	input logic       drive_dominant,
	input logic       bias_enable
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	int dom_cnt; // Consecutive cycles of dominant drive
	int clp_cnt; // Cycles of bus dominant unseen on the receive pin
	// Counters give long spans without huge repetition counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dom_cnt <= 0;
		else
			dom_cnt <= drive_dominant ? dom_cnt + 1 : 0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			clp_cnt <= 0;
		else if (bus_level_comparator && rxd_sense && !undervoltage)
			clp_cnt <= clp_cnt + 1;
		else
			clp_cnt <= 0;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_uv_off;
		undervoltage [*3] |-> !drive_dominant && !bias_enable && rxd_out;
	endproperty
	property p_ot_off;
		overtemperature [*3] |-> !drive_dominant;
	endproperty
	property p_txd_rec;
		txd_pin [*8] |-> !drive_dominant;
	endproperty
	property p_dom_to;
		dom_cnt <= DOM_CYC + 8;
	endproperty
	// Sync and mode latency are allowed as margin
	property p_clamp;
		clp_cnt >= CLAMP_CYC + 8 |-> !drive_dominant;
	endproperty
	property p_low_power_select;
		low_power_select [*8] |-> !bias_enable;
	endproperty
	property p_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	property p_err;
		pslverr |-> pready && paddr != 8'h00 && paddr != 8'h04;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("bus held in low supply");
	a_ot_off: assert property (p_ot_off) else $error("driver on when hot");
	a_txd_rec: assert property (p_txd_rec) else $error("dominant on txd high");
	a_dom_to: assert property (p_dom_to) else $error("dominant too long");
	a_clamp: assert property (p_clamp) else $error("clamp not caught");
	a_low_power_select: assert property (p_low_power_select) else $error("bias on in standby");
	a_ready: assert property (p_ready) else $error("ready timing wrong");
	a_err: assert property (p_err) else $error("error on mapped word");
	c_wake: cover property (!bias_enable && $fell(rxd_out));
	c_clamp: cover property (clp_cnt == CLAMP_CYC + 8);
	c_dom: cover property (dom_cnt == DOM_CYC);
	c_err: cover property (pslverr);
endmodule : cft_checker

bind cft_transceiver cft_checker #(.FILT_CYC(FILT_CYC),
	.WAKE_CYC(WAKE_CYC), .CLAMP_CYC(CLAMP_CYC), .DOM_CYC(DOM_CYC))
	cft_checker_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.txd_pin(txd_pin), .low_power_select(low_power_select),
	.bus_level_comparator(bus_level_comparator), .rxd_sense(rxd_sense),
	.undervoltage(undervoltage), .overtemperature(overtemperature),
	.rxd_out(rxd_out), .drive_dominant(drive_dominant),
	.bias_enable(bias_enable));

/* testbench/cft_ctrl_model.sv */
// Model of the host protocol controller facing the transceiver.
// Assumes the bench calls drive() right after a rising pclk edge.
`timescale 1ns/1ps
module cft_ctrl_model (
	input  logic       pclk,
	input  logic       rxd_out,
	input  logic       clamp_fault,
	input  logic       auto_wake,
	input  logic [3:0] resp_dly,
	output logic       txd_pin          = 1'b1,
	output logic       low_power_select = 1'b1,
	output logic       rxd_sense
);
	int wait_n = 0; // Cycles a wake request has stood unanswered

	// Pin shorted high when a clamp fault is commanded
	assign rxd_sense = clamp_fault ? 1'b1 : rxd_out;

	// Host drives both pins; high in standby keeps current low
	task automatic drive(input logic txd, input logic lps);
		txd_pin <= txd;
		low_power_select <= lps;
	endtask : drive

	// Optional answer to a wake request, prompt or delayed
	always @(posedge pclk) begin
		wait_n <= (low_power_select && !rxd_out) ? wait_n + 1 : 0;
		if (auto_wake && wait_n > resp_dly) begin
			txd_pin <= 1'b1;
			low_power_select <= 1'b0;
		end
	end
endmodule : cft_ctrl_model

/* testbench/tb_top.sv */
// Self-checking bench for the transceiver supervisory block.
// Assumes short parameter values so the run stays brief.
`timescale 1ns/1ps
module tb_top;
	localparam int F = 8;   // Filter cycles
	localparam int W = 200; // Wake timeout cycles
	localparam int C = 6;   // Clamp detect cycles
	localparam int D = 50;  // Dominant hold cycles
	logic        pclk = 1'b0, presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, txd_pin, lps, cmp, rxs;
	logic        uv = 1'b0, ot = 1'b0, bus_ext = 1'b0, clamp_fault = 1'b0;
	logic        auto_wake = 1'b0, rxd_out, drive_dominant, bias_enable;
	logic [3:0]  resp_dly = 4'h0;
	logic [7:0]  a;
	logic        t, b;
	int          seed = 32'h4aac, n_mismatch = 0, cmp_count = 0;
	int          d1, r, d2;
	int          tab[3][3] = '{'{14, 14, 14}, '{14, 250, 14}, '{300, 3, 3}};

	// Bus is dominant if this node or another drives it
	assign cmp = drive_dominant | bus_ext;
	always #12.5 pclk = ~pclk;

	cft_transceiver #(.FILT_CYC(F), .WAKE_CYC(W), .CLAMP_CYC(C),
		.DOM_CYC(D)) cft_transceiver_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .txd_pin(txd_pin), .low_power_select(lps),
		.bus_level_comparator(cmp), .rxd_sense(rxs), .undervoltage(uv),
		.overtemperature(ot), .rxd_out(rxd_out),
		.drive_dominant(drive_dominant), .bias_enable(bias_enable));
	cft_ctrl_model cft_ctrl_model_i (.pclk(pclk), .rxd_out(rxd_out),
		.clamp_fault(clamp_fault), .auto_wake(auto_wake),
		.resp_dly(resp_dly), .txd_pin(txd_pin), .low_power_select(lps),
		.rxd_sense(rxs));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic pin(input logic txd, input logic sel);
		cft_ctrl_model_i.drive(txd, sel);
	endtask : pin
	// One APB transfer; waits for pready, the watchdog bounds a hang
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic mode_is(input logic [1:0] m);
		apb(1'b0, cft_pkg::STATUS_OFS, 32'h0);
		chk(rd[1:0], m);
	endtask : mode_is
	// Valid only if every phase beats the filter and all fits in time
	function automatic logic exp_wake(input int x, input int y,
		input int z);
		return x > F && y > F && z > F && x + y + z < W;
	endfunction : exp_wake
	task automatic wake_seq(input int x, input int y, input int z);
		bus_ext <= 1'b1;
		tick(x);
		bus_ext <= 1'b0;
		tick(y);
		bus_ext <= 1'b1;
		tick(z);
		bus_ext <= 1'b0;
		tick(12);
	endtask : wake_seq
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// Watchdog well past the expected run length
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		tick(8);
		mode_is(cft_pkg::M_STANDBY);
		chk(rd[7:2], 6'h00);
		chk(rxd_out, 1'b1);
		apb(1'b0, cft_pkg::CONTROL_OFS, 32'h0);
		chk(rd[0], cft_pkg::CT_CLAMP_EN_RST);
		apb(1'b1, cft_pkg::STATUS_OFS, $random(seed));
		chk(er, 1'b0);
		mode_is(cft_pkg::M_STANDBY);
		// Unmapped words answer with an error
		for (int i = 0; i < 4; i++) begin
			a = 8'h08 + 8'(({$random(seed)} % 62) * 4);
			apb(i[0], a, $random(seed));
			chk(er, 1'b1);
			chk(rd & {32{~i[0]}}, 32'h0);
		end
		// Normal is refused while txd is low
		pin(1'b0, 1'b0);
		tick(12);
		mode_is(cft_pkg::M_STANDBY);
		pin(1'b1, 1'b0);
		tick(8);
		mode_is(cft_pkg::M_NORMAL);
		// Random transmit and bus traffic in normal mode
		repeat (24) begin
			t = $random(seed);
			b = $random(seed);
			pin(t, 1'b0);
			bus_ext <= b;
			tick(12);
			chk(drive_dominant, !t);
			chk(rxd_out, !(b | !t));
			pin(1'b1, 1'b0);
			bus_ext <= 1'b0;
			tick(4);
		end
		// Dominant hold timeout, then timer reset by a high phase
		pin(1'b0, 1'b0);
		tick(D + 10);
		chk(drive_dominant, 1'b0);
		apb(1'b0, cft_pkg::STATUS_OFS, 32'h0);
		chk(rd[cft_pkg::ST_TO_BIT], 1'b1);
		pin(1'b1, 1'b0);
		tick(8);
		pin(1'b0, 1'b0);
		tick(8);
		chk(drive_dominant, 1'b1);
		// Overtemperature lock holds until txd is high again
		ot <= 1'b1;
		tick(3);
		chk(drive_dominant, 1'b0);
		ot <= 1'b0;
		tick(4);
		chk(drive_dominant, 1'b0);
		pin(1'b1, 1'b0);
		tick(6);
		pin(1'b0, 1'b0);
		tick(8);
		chk(drive_dominant, 1'b1);
		pin(1'b1, 1'b0);
		// Clamp detection off: stays in normal
		apb(1'b1, cft_pkg::CONTROL_OFS, 32'h0);
		clamp_fault <= 1'b1;
		bus_ext <= 1'b1;
		tick(C + 12);
		mode_is(cft_pkg::M_NORMAL);
		clamp_fault <= 1'b0;
		bus_ext <= 1'b0;
		apb(1'b1, cft_pkg::CONTROL_OFS, 32'h1);
		// Clamp into silent; leave by receive low, then by standby
		for (int k = 0; k < 2; k++) begin
			clamp_fault <= 1'b1;
			bus_ext <= 1'b1;
			tick(C + 12);
			mode_is(cft_pkg::M_SILENT);
			pin(1'b0, 1'b0);
			tick(8);
			chk({drive_dominant, bias_enable, rxd_out}, 3'b010);
			pin(1'b1, k[0]);
			clamp_fault <= k[0];
			tick(10);
			mode_is(k ? cft_pkg::M_STANDBY : cft_pkg::M_NORMAL);
			clamp_fault <= 1'b0;
			bus_ext <= 1'b0;
			pin(1'b1, 1'b0);
			tick(10);
		end
		// Low supply: bus released, select ignored, no wake
		pin(1'b0, 1'b0);
		tick(6);
		uv <= 1'b1;
		tick(3);
		chk({drive_dominant, bias_enable, rxd_out}, 3'b001);
		pin(1'b1, 1'b1);
		tick(4);
		pin(1'b1, 1'b0);
		wake_seq(14, 14, 14);
		chk({bias_enable, rxd_out}, 2'b01);
		apb(1'b0, cft_pkg::STATUS_OFS, 32'h0);
		chk({rd[5], rd[1:0]}, 3'b100);
		uv <= 1'b0;
		tick(12);
		mode_is(cft_pkg::M_NORMAL);
		// Wake patterns: table corners then random phase lengths
		for (int i = 0; i < 9; i++) begin
			d1 = i < 3 ? tab[i][0] : ($random(seed) & 1) ? 14 : 3;
			r = i < 3 ? tab[i][1] : ($random(seed) & 1) ? 14 : 3;
			d2 = i < 3 ? tab[i][2] : ($random(seed) & 1) ? 14 : 3;
			pin(1'b1, 1'b1);
			tick(230);
			wake_seq(d1, r, d2);
			chk(rxd_out, !exp_wake(d1, r, d2));
			chk(bias_enable, 1'b0);
			pin(1'b1, 1'b0);
			tick(10);
		end
		// Host answers a wake request after a delay
		pin(1'b1, 1'b1);
		resp_dly <= 4'h5;
		auto_wake <= 1'b1;
		tick(230);
		wake_seq(14, 14, 14);
		tick(12);
		chk(bias_enable, 1'b1);
		auto_wake <= 1'b0;
		close_out();
	end
endmodule : tb_top
